// ---- timer_pin_io_mode_decode.sv ----
// Mode decode, compare and capture logic for three timer general registers.
`timescale 1ns/1ps
`include "timer_io_defines.svh"

module timer_pin_io_mode_decode #(
    parameter int CNT_W = 16
) (
    // Clock and asynchronous active-low reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Index 0 is channel 0 register D, 1 is channel 1 B, 2 is channel 2 B.
    input wire logic [2:0] ioCtrlWrEn,
    input wire logic [2:0][7:0] ioCtrlWrData,
    output logic [2:0][3:0] ioSelField,
    // Software access to the general registers and their contents.
    input wire logic [2:0] genRegWrEn,
    input wire logic [2:0][CNT_W-1:0] genRegWrData,
    output logic [2:0][CNT_W-1:0] genRegValue,
    // Counters of the owning channels, the cross-channel event sources and the buffer select of channel 0 register D.
    input wire logic [2:0][CNT_W-1:0] counterValue,
    input wire logic ch1CountTick,
    input wire logic ch0RegCEvent,
    input wire logic bufferModeB,
    // External pin levels in, pin level and drive enable out.
    input wire logic [2:0] pinIn,
    output logic [2:0] pinOut,
    output logic [2:0] pinOe,
    // One-cycle compare match and capture pulses per register.
    output timer_io_pkg::chan_event_s [2:0] chanEvent
);

    // The three registers share one decode; only channel 2 register B differs, in
    // treating codes 11xx as 10xx. Channel 0 register D alone can be made a buffer,
    // which stops its events and freezes its pin level while its stored field stays readable.

    // Turns a select field into the register's function. Codes with bit 3 clear are
    // compare codes; bit 6 picks the initial level and bits 5 and 4 the match action.
    // Codes with bit 3 set are capture codes; codes 11xx pick the cross-channel source
    // except on channel 2 register B, where bit 6 is ignored and they act as 10xx.
    // Every code is listed on purpose, so that a reader can hold each line of the
    // decode against the code table without working out the bit tests by hand.
    function automatic timer_io_pkg::io_mode_s decodeIo(
        input logic [3:0] sel,
        input logic [1:0] chan
    );
        timer_io_pkg::io_mode_s m;
        logic crossCapable;
        m = '0;
        crossCapable = (chan != `CH2_REG_B);
        case (sel)
            4'h0, 4'h4: begin
                m.isCompare = 1'b1;
                m.initLevel = sel[2];
                m.action = timer_io_pkg::ACT_KEEP;
            end
            4'h1, 4'h5: begin
                m.isCompare = 1'b1;
                m.initLevel = sel[2];
                m.action = timer_io_pkg::ACT_LOW;
            end
            4'h2, 4'h6: begin
                m.isCompare = 1'b1;
                m.initLevel = sel[2];
                m.action = timer_io_pkg::ACT_HIGH;
            end
            4'h3, 4'h7: begin
                m.isCompare = 1'b1;
                m.initLevel = sel[2];
                m.action = timer_io_pkg::ACT_TOGGLE;
            end
            4'h8: begin
                m.captureRise = 1'b1;
            end
            4'h9: begin
                m.captureFall = 1'b1;
            end
            4'hA, 4'hB: begin
                m.captureRise = 1'b1;
                m.captureFall = 1'b1;
            end
            4'hC: begin
                if (crossCapable) begin
                    m.crossSource = 1'b1;
                end else begin
                    m.captureRise = 1'b1;
                end
            end
            4'hD: begin
                if (crossCapable) begin
                    m.crossSource = 1'b1;
                end else begin
                    m.captureFall = 1'b1;
                end
            end
            4'hE, 4'hF: begin
                if (crossCapable) begin
                    m.crossSource = 1'b1;
                end else begin
                    m.captureRise = 1'b1;
                    m.captureFall = 1'b1;
                end
            end
            default: begin
                m = '0;
            end
        endcase
        return m;
    endfunction

    // Works out the pin level that a compare match leaves behind. Keep codes hold the
    // level, so a match under code 0000 or 0100 is seen on the event port only.
    function automatic logic pinAfterMatch(
        input timer_io_pkg::out_action_e action,
        input logic level
    );
        logic result;
        case (action)
            timer_io_pkg::ACT_KEEP: result = level;
            timer_io_pkg::ACT_LOW: result = 1'b0;
            timer_io_pkg::ACT_HIGH: result = 1'b1;
            timer_io_pkg::ACT_TOGGLE: result = !level;
            default: result = level;
        endcase
        return result;
    endfunction

    // Tells whether a synchronised pin moved in a direction that the mode listens to.
    // Both samples come from the second and third stages, so the first stage, which
    // may still be settling, never feeds any logic but the second.
    function automatic logic edgeMatches(
        input timer_io_pkg::io_mode_s m,
        input logic curLevel,
        input logic prevLevel
    );
        logic rising;
        logic falling;
        rising = curLevel && !prevLevel;
        falling = !curLevel && prevLevel;
        return (m.captureRise && rising) || (m.captureFall && falling);
    endfunction

    // Cross-channel capture sources per register. Register D of channel 0 listens to
    // the channel 1 count tick and register B of channel 1 to register C of channel 0.
    // Channel 2 has no cross source, so its 11xx codes fall back to pin capture and
    // its bit here is tied low.
    logic [2:0] crossEvt;
    assign crossEvt = {1'b0, ch0RegCEvent, ch1CountTick};

    // Pin synchroniser stages; the third stage only holds the previous settled level
    // so that edges can be told apart.
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] sync1_next;
    logic [2:0] sync2_next;
    logic [2:0] sync3_next;

    // Pin inputs pass two flip-flops, the third one only feeds edge detection.
    // The stages reset low, the level the pins show while compare mode drives 0,
    // so no false edge follows reset.
    always_comb begin
        sync1_next = pinIn;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
    end

    // Registers the pin synchronisers.
    // The reset branch loads constants only.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
        end
    end

    // One copy of the register logic per general register: index 0 is channel 0
    // register D, index 1 channel 1 register B and index 2 channel 2 register B.
    // The index is also handed to the decode so that channel 2 can differ.
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_chan
            // Stored state of this register: select field, value, pin and event pulses.
            // The previous equality flag makes a long equality match only once.
            logic [3:0] ioSel_reg;
            logic [3:0] ioSel_next;
            logic [CNT_W-1:0] genReg_reg;
            logic [CNT_W-1:0] genReg_next;
            logic pin_reg;
            logic pin_next;
            logic eqPrev_reg;
            logic eqPrev_next;
            logic match_reg;
            logic match_next;
            logic capture_reg;
            logic capture_next;

            // Decoded function of the stored field and of the field being written.
            // The written one is needed for the initial pin level.
            timer_io_pkg::io_mode_s mode;
            timer_io_pkg::io_mode_s newMode;
            logic [3:0] newSel;

            // Conditions of the current cycle.
            // Active is low only while register D of channel 0 is a buffer.
            logic active;
            logic isEqual;
            logic edgeHit;

            // Decodes the current and the incoming select field.
            // Bits 3 to 0 of the written byte belong to the other register and are dropped.
            always_comb begin
                newSel = ioCtrlWrData[ch][`IO_SEL_MSB:`IO_SEL_LSB];
                mode = decodeIo(ioSel_reg, 2'(ch));
                newMode = decodeIo(newSel, 2'(ch));
            end

            // Sees whether the pin moved in a direction that the mode listens to, and
            // whether the counter stands at the general register value.
            // Only register D of channel 0 can be made a buffer.
            always_comb begin
                active = !((ch == 0) && bufferModeB);
                isEqual = (counterValue[ch] == genReg_reg);
                edgeHit = edgeMatches(mode, sync2_reg[ch], sync3_reg[ch]);
                eqPrev_next = isEqual;
            end

            // Forms the match and capture pulses; equality held over several cycles
            // matches once, and a buffered register makes no event at all.
            always_comb begin
                match_next = active && mode.isCompare && isEqual && !eqPrev_reg;
                capture_next = active && (edgeHit || (mode.crossSource && crossEvt[ch]));
            end

            // Next select field; only bits 7 to 4 of the written byte are kept.
            // The field is stored even while the register is a buffer.
            always_comb begin
                ioSel_next = ioSel_reg;
                if (ioCtrlWrEn[ch]) begin
                    ioSel_next = newSel;
                end
            end

            // Next general register value; a capture wins over a software write.
            // Losing the write is the lesser harm: the captured count cannot be
            // taken again, while software can repeat its write.
            always_comb begin
                genReg_next = genReg_reg;
                if (capture_next) begin
                    genReg_next = counterValue[ch];
                end else if (genRegWrEn[ch]) begin
                    genReg_next = genRegWrData[ch];
                end
            end

            // Next pin level: initial level on a field write, action on a match.
            // A field write in the same cycle as a match wins, so a new low, high or toggle
            // code starts from its stated initial level outside buffer mode; keep codes leave the pin as is.
            always_comb begin
                pin_next = pin_reg;
                if (ioCtrlWrEn[ch] && active) begin
                    if (newMode.isCompare && (newMode.action != timer_io_pkg::ACT_KEEP)) begin
                        pin_next = newMode.initLevel;
                    end
                end else if (match_next) begin
                    pin_next = pinAfterMatch(mode.action, pin_reg);
                end
            end

            // Registers the per-channel state.
            // After reset the field is 0000, so the pin is driven at 0 until a
            // field write picks another code.
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ioSel_reg <= `IO_SEL_RESET;
                    genReg_reg <= CNT_W'(`GEN_REG_RESET);
                    pin_reg <= `PIN_RESET;
                    eqPrev_reg <= 1'b0;
                    match_reg <= 1'b0;
                    capture_reg <= 1'b0;
                end else begin
                    ioSel_reg <= ioSel_next;
                    genReg_reg <= genReg_next;
                    pin_reg <= pin_next;
                    eqPrev_reg <= eqPrev_next;
                    match_reg <= match_next;
                    capture_reg <= capture_next;
                end
            end

            // Drives the channel outputs; the pin is driven in compare mode.
            // Capture codes release the pin so that the outside level can be seen.
            // Event pulses come straight from their flip-flops.
            always_comb begin
                ioSelField[ch] = ioSel_reg;
                genRegValue[ch] = genReg_reg;
                pinOut[ch] = pin_reg;
                pinOe[ch] = mode.isCompare;
                chanEvent[ch].compareMatch = match_reg;
                chanEvent[ch].captureEvent = capture_reg;
            end
        end
    endgenerate

endmodule // timer_pin_io_mode_decode

// ---- timer_io_defines.svh ----
// Constants for the timer pin input/output mode decode block.
`ifndef TIMER_IO_DEFINES_SVH
`define TIMER_IO_DEFINES_SVH

`define IO_SEL_MSB 7
`define IO_SEL_LSB 4
`define IO_SEL_RESET 4'h0
`define GEN_REG_RESET 16'h0000
`define PIN_RESET 1'b0
`define CH0_REG_D 2'h0
`define CH1_REG_B 2'h1
`define CH2_REG_B 2'h2
`define NUM_CHANNELS 3

`endif

// ---- timer_io_pkg.sv ----
// Types shared by the timer pin input/output mode decode block.
package timer_io_pkg;

    // Pin action at a compare match, encoded as select bits 5 and 4.
    typedef enum logic [1:0] {
        ACT_KEEP = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOGGLE = 2'h3
    } out_action_e;

    // Decoded function of one general register.
    typedef struct packed {
        logic isCompare;
        logic initLevel;
        out_action_e action;
        logic captureRise;
        logic captureFall;
        logic crossSource;
    } io_mode_s;

    // Events reported for one general register.
    typedef struct packed {
        logic compareMatch;
        logic captureEvent;
    } chan_event_s;

endpackage

// ---- timer_pin_io_mode_decode_assertions.sv ----
// Checker of the timer pin mode decode block, seen from its ports.
`timescale 1ns/1ps
module timer_pin_io_mode_decode_assertions #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [2:0] ioCtrlWrEn,
    input wire logic [2:0][7:0] ioCtrlWrData,
    input wire logic [2:0][3:0] ioSelField,
    input wire logic [2:0][CNT_W-1:0] genRegValue,
    input wire logic [2:0][CNT_W-1:0] counterValue,
    input wire logic ch1CountTick,
    input wire logic ch0RegCEvent,
    input wire logic bufferModeB,
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    input wire timer_io_pkg::chan_event_s [2:0] chanEvent
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // A match taken under a quiet compare code, low action or toggle action.
    sequence s_low;
        !ioCtrlWrEn[1] && !ioSelField[1][3] && ioSelField[1][1:0] == 2'h1 ##1 chanEvent[1].compareMatch;
    endsequence
    sequence s_tog;
        !ioCtrlWrEn[1] && !ioSelField[1][3] && ioSelField[1][1:0] == 2'h3 ##1 chanEvent[1].compareMatch;
    endsequence
    property p_sel; ioCtrlWrEn[1] |=> ioSelField[1] == $past(ioCtrlWrData[1][7:4]); endproperty
    a_sel: assert property (p_sel) else $error("select field not stored");
    property p_oe; pinOe == ~{ioSelField[2][3], ioSelField[1][3], ioSelField[0][3]}; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_init;
        ioCtrlWrEn[1] && !ioCtrlWrData[1][7] && ioCtrlWrData[1][5:4] != 2'h0
        |=> pinOut[1] == $past(ioCtrlWrData[1][6]);
    endproperty
    a_init: assert property (p_init) else $error("initial level wrong");
    property p_low; s_low |-> !pinOut[1]; endproperty
    a_low: assert property (p_low) else $error("pin not driven low");
    property p_tog; s_tog |-> pinOut[1] != $past(pinOut[1]); endproperty
    a_tog: assert property (p_tog) else $error("pin not toggled");
    property p_tick;
        ioSelField[0][3:2] == 2'h3 && !bufferModeB && ch1CountTick
        |=> chanEvent[0].captureEvent && genRegValue[0] == $past(counterValue[0]);
    endproperty
    a_tick: assert property (p_tick) else $error("count capture missed");
    property p_cross;
        ioSelField[1][3:2] == 2'h3 && ch0RegCEvent
        |=> chanEvent[1].captureEvent && genRegValue[1] == $past(counterValue[1]);
    endproperty
    a_cross: assert property (p_cross) else $error("cross capture missed");
    property p_buf; bufferModeB |=> chanEvent[0] == 2'h0; endproperty
    a_buf: assert property (p_buf) else $error("event while buffered");
endmodule // timer_pin_io_mode_decode_assertions

bind timer_pin_io_mode_decode timer_pin_io_mode_decode_assertions #(.CNT_W(CNT_W)) u_chk (
    .ref_clk, .resetn, .ioCtrlWrEn, .ioCtrlWrData, .ioSelField, .genRegValue, .counterValue,
    .ch1CountTick, .ch0RegCEvent, .bufferModeB, .pinOut, .pinOe, .chanEvent);

// ---- timer_pin_partner.sv ----
// Model of the three external timer pins.
`timescale 1ns/1ps
module timer_pin_partner (
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    input wire logic [2:0] extLevel,
    output logic [2:0] pinIn
);
    // Each wire shows the block's level while it drives, else the outside source.
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // timer_pin_partner

// ---- timer_pin_io_mode_decode_tb.sv ----
// Self-checking bench of the timer pin mode decode block.
`timescale 1ns/1ps
module timer_pin_io_mode_decode_tb;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic ch1CountTick = 1'h0, ch0RegCEvent = 1'h0, bufferModeB = 1'h0;
    logic [2:0] ioCtrlWrEn = 3'h0, genRegWrEn = 3'h0, extLevel = 3'h0, pinIn, pinOut, pinOe;
    logic [2:0][7:0] ioCtrlWrData = '0;
    logic [2:0][3:0] ioSelField;
    logic [2:0][15:0] genRegWrData = '0, genRegValue, counterValue = '0;
    timer_io_pkg::chan_event_s [2:0] chanEvent;
    int miscompares = 0, checks = 0, cycles = 0, capCnt = 0;
    always #5 ref_clk = ~ref_clk;
    timer_pin_io_mode_decode #(.CNT_W(16)) u_dut (.ref_clk, .resetn, .ioCtrlWrEn, .ioCtrlWrData,
        .ioSelField, .genRegWrEn, .genRegWrData, .genRegValue, .counterValue, .ch1CountTick,
        .ch0RegCEvent, .bufferModeB, .pinIn, .pinOut, .pinOe, .chanEvent);
    timer_pin_partner u_pins (.pinOut, .pinOe, .extLevel, .pinIn);
    // Counts channel 2 capture pulses and cuts a hung run short.
    always @(posedge ref_clk) begin
        capCnt += int'(chanEvent[2].captureEvent);
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wc(input int i, input logic [7:0] d);
        ioCtrlWrEn[i] = 1'h1;
        ioCtrlWrData[i] = d;
        cyc(1);
        ioCtrlWrEn[i] = 1'h0;
    endtask
    task automatic wg(input int i, input logic [15:0] v);
        genRegWrEn[i] = 1'h1;
        genRegWrData[i] = v;
        cyc(1);
        genRegWrEn[i] = 1'h0;
    endtask
    // One compare match on channel 1: level after the write, then after the match.
    task automatic cmp(input logic [7:0] d, input logic e0, input logic e1);
        wc(1, d);
        chk(pinOut[1], e0);
        counterValue[1] = 16'h0010;
        cyc(1);
        chk(chanEvent[1], 16'h0002);
        chk(pinOut[1], e1);
        cyc(1);
        chk(chanEvent[1], 16'h0000);
        counterValue[1] = 16'h0000;
        cyc(1);
    endtask
    // One pin level change on channel 2 under a capture code.
    task automatic cap(input logic [7:0] d, input logic lv, input int n);
        int k;
        wc(2, d);
        wg(2, 16'h0000);
        k = capCnt;
        extLevel[2] = lv;
        cyc(6);
        chk(pinOe[2], 16'h0000);
        chk(16'(capCnt - k), 16'(n));
        chk(genRegValue[2], (n != 0) ? 16'h02A5 : 16'h0000);
    endtask
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        logic lvl;
        lvl = 1'h0;
        cyc(4);
        resetn = 1'h1;
        chk(ioSelField, 16'h0000);
        chk(pinOut, 16'h0000);
        chk(pinOe, 16'h0007);
        for (int c = 0; c < 8; c++) begin
            wc(1, {c[3:0], 4'hF});
            if (c[1:0] != 2'h0) lvl = c[2];
            chk(ioSelField[1], 16'(c[3:0]));
            chk(pinOut[1], lvl);
        end
        wc(1, 8'h40);
        chk(pinOut[1], lvl);
        wg(1, 16'h0010);
        cmp(8'h20, 1'h0, 1'h1);
        cmp(8'h40, 1'h1, 1'h1);
        cmp(8'h50, 1'h1, 1'h0);
        cmp(8'h30, 1'h0, 1'h1);
        cmp(8'h70, 1'h1, 1'h0);
        counterValue[2] = 16'h02A5;
        cap(8'h80, 1'h1, 1);
        cap(8'h80, 1'h0, 0);
        cap(8'h90, 1'h1, 0);
        cap(8'h90, 1'h0, 1);
        cap(8'hC0, 1'h1, 1);
        cap(8'hA0, 1'h0, 1);
        cap(8'hB0, 1'h1, 1);
        counterValue[0] = 16'h1234;
        counterValue[1] = 16'h0BEE;
        wc(0, 8'hC0);
        wc(1, 8'hD0);
        ch1CountTick = 1'h1;
        ch0RegCEvent = 1'h1;
        cyc(1);
        ch1CountTick = 1'h0;
        ch0RegCEvent = 1'h0;
        chk(chanEvent[0], 16'h0001);
        chk(genRegValue[0], 16'h1234);
        chk(genRegValue[1], 16'h0BEE);
        chk(chanEvent[1], 16'h0001);
        bufferModeB = 1'h1;
        counterValue[0] = 16'h5678;
        ch1CountTick = 1'h1;
        cyc(1);
        ch1CountTick = 1'h0;
        wc(0, 8'h70);
        chk(genRegValue[0], 16'h1234);
        chk(pinOut[0], 16'h0000);
        conclude();
    end
endmodule // timer_pin_io_mode_decode_tb
